// >>> common/ccr_defs.svh
`ifndef CCR_DEFS_SVH
`define CCR_DEFS_SVH

`define CCR_ADDR_W        12
`define CCR_IDX_W         10
`define CCR_IDX_TESTCELL  10'h054
`define CCR_IDX_ROLLOVER  10'h055
`define CCR_IDX_MODE      10'h060
`define CCR_ROLLOVER_RST  16'h0000
`define CCR_TESTCELL_RST  16'h0000
`define CCR_MODE_RST      1'h0
`define CCR_CH0_MASK      16'h1111
`define CCR_ALL_MASK      16'hFFFF
`define CCR_TC_CH0_MASK   16'h0001
`define CCR_TC_IMPL_MASK  16'h0001
`define CCR_MODE_CONCAT_BIT 0

`endif

// >>> common/ccr_pkg.sv
package ccr_pkg;

  // bit order matches the flag register, msb first
  typedef struct packed {
    logic tx_assigned3_wrap;
    logic tx_assigned2_wrap;
    logic tx_assigned1_wrap;
    logic tx_assigned0_wrap;
    logic tx_idle3_wrap;
    logic tx_idle2_wrap;
    logic tx_idle1_wrap;
    logic tx_idle0_wrap;
    logic rx_assigned3_wrap;
    logic rx_assigned2_wrap;
    logic rx_assigned1_wrap;
    logic rx_assigned0_wrap;
    logic rx_idle3_wrap;
    logic rx_idle2_wrap;
    logic rx_idle1_wrap;
    logic rx_idle0_wrap;
  } ccr_wrap_s;

  typedef logic [15:0] ccr_flags_t;

endpackage

// >>> hdl/ccr_flag_bit.sv
`timescale 1ns/1ps
`default_nettype none

module ccr_flag_bit (
  input  wire logic ref_clk,
  input  wire logic arst_n,
  input  wire logic set_evt,
  input  wire logic clr_req,
  output var  logic flag
);

  logic next_flag;

  // set beats a clear in the same cycle
  assign next_flag = set_evt | (flag & ~clr_req);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag;
    end
  end

endmodule

`default_nettype wire

// >>> hdl/ccr_rollover_flags.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccr_defs.svh"

module ccr_rollover_flags (
  input  wire logic                    ref_clk,
  input  wire logic                    arst_n,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`CCR_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]             pwdata,
  input  wire logic [3:0]              pstrb,
  output var  logic [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire ccr_pkg::ccr_wrap_s      wrap_evt,
  input  wire logic                    analyzer0_rx_wrap,
  output var  logic                    concat_mode
);

  // address decode
  wire [`CCR_IDX_W-1:0] acc_idx;
  wire                  aligned;
  wire                  hit_roll;
  wire                  hit_tc;
  wire                  hit_mode;
  wire                  hit_any;
  wire                  setup;
  wire                  access;
  wire                  wr_stb;

  assign acc_idx  = paddr[`CCR_ADDR_W-1:2];
  assign aligned  = (paddr[1:0] == 2'h0);
  assign hit_roll = aligned && (acc_idx == `CCR_IDX_ROLLOVER);
  assign hit_tc   = aligned && (acc_idx == `CCR_IDX_TESTCELL);
  assign hit_mode = aligned && (acc_idx == `CCR_IDX_MODE);
  assign hit_any  = hit_roll | hit_tc | hit_mode;
  assign setup    = psel & ~penable;
  assign access   = psel & penable;
  assign wr_stb   = access & pwrite & hit_any;

  // zero wait states; unmapped or misaligned accesses answer with an error
  assign pready  = 1'b1;
  assign pslverr = access & ~hit_any;

  // write-one-to-clear masks, per byte lane
  wire [15:0] lane_mask;
  wire [15:0] clr_roll;
  wire [15:0] clr_tc;

  assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  wire        wr_roll;
  wire        wr_tc;
  wire [15:0] clr_bits;

  assign wr_roll  = wr_stb & hit_roll;
  assign wr_tc    = wr_stb & hit_tc;
  // only ones in enabled lanes clear, zeros leave a flag alone
  assign clr_bits = pwdata[15:0] & lane_mask;
  assign clr_roll = wr_roll ? clr_bits : 16'h0000;
  assign clr_tc   = wr_tc ? clr_bits : 16'h0000;

  // mode control register
  wire mode_wr;
  wire next_concat_mode;

  assign mode_wr          = wr_stb & hit_mode & pstrb[0];
  assign next_concat_mode = mode_wr ? pwdata[`CCR_MODE_CONCAT_BIT] : concat_mode;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      concat_mode <= `CCR_MODE_RST;
    end else begin
      concat_mode <= next_concat_mode;
    end
  end

  // channels 1..3 valid only in four-channel mode
  wire [15:0] roll_valid;
  wire [15:0] tc_valid;

  wire four_chan;

  assign four_chan = ~concat_mode;

  assign roll_valid[15] = four_chan;
  assign roll_valid[14] = four_chan;
  assign roll_valid[13] = four_chan;
  assign roll_valid[12] = 1'b1;

  assign roll_valid[11] = four_chan;
  assign roll_valid[10] = four_chan;
  assign roll_valid[9]  = four_chan;
  assign roll_valid[8]  = 1'b1;

  assign roll_valid[7]  = four_chan;
  assign roll_valid[6]  = four_chan;
  assign roll_valid[5]  = four_chan;
  assign roll_valid[4]  = 1'b1;

  assign roll_valid[3]  = four_chan;
  assign roll_valid[2]  = four_chan;
  assign roll_valid[1]  = four_chan;
  assign roll_valid[0]  = 1'b1;

  assign tc_valid   = `CCR_TC_CH0_MASK & `CCR_TC_IMPL_MASK;

  // event mapping onto flag bits
  ccr_pkg::ccr_flags_t roll_evt;
  ccr_pkg::ccr_flags_t tc_evt;
  ccr_pkg::ccr_flags_t roll_set;
  ccr_pkg::ccr_flags_t tc_set;

  assign roll_evt[15] = wrap_evt.tx_assigned3_wrap;
  assign roll_evt[14] = wrap_evt.tx_assigned2_wrap;
  assign roll_evt[13] = wrap_evt.tx_assigned1_wrap;
  assign roll_evt[12] = wrap_evt.tx_assigned0_wrap;
  assign roll_evt[11] = wrap_evt.tx_idle3_wrap;
  assign roll_evt[10] = wrap_evt.tx_idle2_wrap;
  assign roll_evt[9]  = wrap_evt.tx_idle1_wrap;
  assign roll_evt[8]  = wrap_evt.tx_idle0_wrap;
  assign roll_evt[7]  = wrap_evt.rx_assigned3_wrap;
  assign roll_evt[6]  = wrap_evt.rx_assigned2_wrap;
  assign roll_evt[5]  = wrap_evt.rx_assigned1_wrap;
  // receive assigned 0 and idle bits kept with the same sticky kind
  assign roll_evt[4]  = wrap_evt.rx_assigned0_wrap;
  assign roll_evt[3]  = wrap_evt.rx_idle3_wrap;
  assign roll_evt[2]  = wrap_evt.rx_idle2_wrap;
  assign roll_evt[1]  = wrap_evt.rx_idle1_wrap;
  assign roll_evt[0]  = wrap_evt.rx_idle0_wrap;

  assign tc_evt = {15'h0000, analyzer0_rx_wrap};

  assign roll_set = roll_evt & roll_valid;
  assign tc_set   = tc_evt & tc_valid;

  // sticky flag storage
  ccr_pkg::ccr_flags_t roll_flag;
  ccr_pkg::ccr_flags_t tc_flag;

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_roll
      ccr_flag_bit u_roll (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .set_evt (roll_set[gi]),
        .clr_req (clr_roll[gi]),
        .flag    (roll_flag[gi])
      );
    end
  endgenerate

  ccr_flag_bit u_tc0 (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .set_evt (tc_set[0]),
    .clr_req (clr_tc[0]),
    .flag    (tc_flag[0])
  );
  assign tc_flag[15:1] = 15'h0000;

  // read mux, invalid channels read as zero
  wire [15:0] roll_view;
  wire [15:0] tc_view;
  wire [31:0] rd_mux;
  wire [31:0] next_prdata;

  assign roll_view = roll_flag & roll_valid;
  assign tc_view   = tc_flag & tc_valid;
  wire [31:0] roll_word;
  wire [31:0] tc_word;
  wire [31:0] mode_word;
  wire        rd_setup;

  assign roll_word = hit_roll ? {16'h0000, roll_view} : 32'h00000000;
  assign tc_word   = hit_tc ? {16'h0000, tc_view} : 32'h00000000;
  assign mode_word = hit_mode ? {31'h00000000, concat_mode} : 32'h00000000;
  assign rd_mux    = roll_word | tc_word | mode_word;
  assign rd_setup  = setup & ~pwrite;
  // captured in setup so data is steady through the access phase
  assign next_prdata = rd_setup ? rd_mux : prdata;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h00000000;
    end else begin
      prdata <= next_prdata;
    end
  end

endmodule

`default_nettype wire

// >>> sim/ccr_rollover_flags_checker.sv
`timescale 1ns/1ps
`default_nettype none

module ccr_rollover_flags_checker (
  input wire logic               ref_clk,
  input wire logic               arst_n,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [11:0]        paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [3:0]         pstrb,
  input wire logic [31:0]        prdata,
  input wire logic               pslverr,
  input wire ccr_pkg::ccr_wrap_s wrap_evt,
  input wire logic               analyzer0_rx_wrap,
  input wire logic               concat_mode
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  wire rd_set = psel && !penable && !pwrite;
  wire acc    = psel && penable;
  sequence rd_roll;
    rd_set && paddr == 12'h154;
  endsequence
  sequence clr_all;
    acc && pwrite && paddr == 12'h154 && pstrb[1:0] == 2'h3 && pwdata[15:0] == 16'hFFFF
      && wrap_evt == 16'h0000;
  endsequence
  a_unmapped_err: assert property (
    acc && !(paddr inside {12'h150, 12'h154, 12'h180}) |-> pslverr) else $error("no slverr");
  a_wr_clear: assert property (
    clr_all ##1 wrap_evt == 16'h0000 ##1 rd_roll |=> prdata[15:0] == 16'h0000)
    else $error("flags not cleared");
  a_read_hold: assert property (
    !rd_set |=> $stable(prdata)) else $error("read data moved");
  a_concat_hide: assert property (
    rd_set && paddr == 12'h154 && concat_mode |=> (prdata & 32'hFFFFEEEE) == 32'h0)
    else $error("invalid flag shown");
  a_ch0_set: assert property (
    (wrap_evt & 16'h1111) != 16'h0 ##1 rd_roll
    |=> (prdata[15:0] & $past(wrap_evt, 2) & 16'h1111) == ($past(wrap_evt, 2) & 16'h1111))
    else $error("channel 0 flag missing");
  a_four_set: assert property (
    wrap_evt != 16'h0 ##1 (rd_set && paddr == 12'h154 && !concat_mode)
    |=> (prdata[15:0] & $past(wrap_evt, 2)) == $past(wrap_evt, 2)) else $error("flag missing");
  a_analyzer_set: assert property (
    analyzer0_rx_wrap ##1 (rd_set && paddr == 12'h150) |=> prdata[0]) else $error("no bit 0");
  a_idle0_set: assert property (
    wrap_evt.tx_idle0_wrap ##1 rd_roll |=> prdata[8]) else $error("no bit 8");
endmodule

bind ccr_rollover_flags ccr_rollover_flags_checker i_ccr_rollover_flags_checker (.*);

`default_nettype wire

// >>> sim/ccr_rollover_flags_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value at %0t got %h exp %h", $time, g, e); end end

module ccr_rollover_flags_test;
  logic               ref_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic               analyzer0_rx_wrap = 0, pready, pslverr, concat_mode, err;
  logic [11:0]        paddr = 0;
  logic [3:0]         pstrb = 4'hF;
  logic [31:0]        pwdata = 0, prdata, rdata;
  ccr_pkg::ccr_wrap_s wrap_evt = '0;
  int                 checks = 0, n_mismatch = 0, cyc = 0;

  ccr_rollover_flags i_ccr_rollover_flags (.*);

  initial begin
    forever #2 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task wrap_up();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge ref_clk);
  endtask

  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 32'h0);
    `CHK(rdata, e)
  endtask

  task pulse(input logic [15:0] v);
    wrap_evt <= v;
    @(posedge ref_clk);
    wrap_evt <= '0;
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    arst_n <= 1;
    @(posedge ref_clk);
    rd(12'h154, 32'h0);
    rd(12'h180, 32'h0);
    $display("test reset done");
    pulse(16'h0100);
    rd(12'h154, 32'h0100);
    pulse(16'hFFFF);
    rd(12'h154, 32'hFFFF);
    rd(12'h154, 32'hFFFF);
    apb(1, 12'h154, 32'h0160);
    rd(12'h154, 32'hFE9F);
    apb(1, 12'h154, 32'hFFFF);
    rd(12'h154, 32'h0);
    $display("test flags done");
    apb(1, 12'h180, 32'h1);
    `CHK(concat_mode, 1'b1)
    pulse(16'hFFFF);
    rd(12'h154, 32'h1111);
    apb(1, 12'h180, 32'h0);
    rd(12'h154, 32'h1111);
    $display("test mode done");
    analyzer0_rx_wrap <= 1;
    @(posedge ref_clk);
    analyzer0_rx_wrap <= 0;
    rd(12'h150, 32'h1);
    rd(12'h200, 32'h0);
    `CHK(err, 1'b1)
    $display("test access done");
    wrap_up();
  end
endmodule

`default_nettype wire
